/* rail_output_delay_sequencer.sv */
// rail and general output start-up / shut-down delay sequencer
//
// Overview of operation
// [R01] step-down B on delay: bits 3-0, rising edge
// [R02] step-down B off delay: bits 7-4, falling edge
// [R03] default range: code times half millisecond
// [R04] long-range bit: one millisecond steps, 15 ms
// [R05] step-up on delay: bits 3-0, rising edge
// [R06] step-up off delay: bits 7-4, falling edge
// [R07] output A on after bits 3-0 delay
// [R08] output A off after bits 7-4 delay
// [R09] output B on after bits 3-0 delay
// [R10] output B off after bits 7-4 delay
// [R11] output C on after bits 3-0 delay
// [R12] output C off after bits 7-4 delay
// [R13] delay fields read-write, reset to zero
// [R14] first control register resets aa, fixed layout
// [R15] control is level bit, optionally ANDed pin
// [R16] separate bit selects shut-down delay range
// [R17] shared tick, independent down-counter per output
// [R18] reversed control abandons pending delay
`timescale 1ns/1ns
`default_nettype none
module rail_output_delay_sequencer #(
  parameter int TICK_CYCLES = seq_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // enable pins
  input wire logic ENABLE_PIN_A,
  input wire logic ENABLE_PIN_B,
  input wire logic ENABLE_PIN_C,
  // rail enables
  output logic STEP_DOWN_B_EN,
  output logic STEP_UP_EN,
  // general outputs, data and output enable
  output logic [2:0] GENERAL_OUT_O,
  output logic [2:0] GENERAL_OUT_OE
);

  // ****************************************
  // types and helpers
  // ****************************************
  typedef struct packed {
    seq_pkg::regs_t regs;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [seq_pkg::NCH-1:0] ctrl_prev;
    logic [seq_pkg::NCH-1:0] out;
    logic [seq_pkg::NCH-1:0][seq_pkg::CNT_W-1:0] cnt;
    logic [31:0] presc;
    logic tick;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] go_o;
    logic [2:0] go_oe;
  } state_t;

  state_t s_q;
  state_t s_d;
  seq_pkg::apb_req_t req;
  logic [seq_pkg::NCH-1:0] ctrl;
  logic [seq_pkg::NCH-1:0][3:0] grp;
  logic [7:0] idx;
  logic hit;

  // control from a level/select group and the synced pins
  function automatic logic ctl_of(input logic [3:0] g, input logic [2:0] pins);
    logic [1:0] sel;
    logic gate;
    sel = g[seq_pkg::G_SEL +: 2];
    gate = 1'b1;
    if (sel != 2'h0)
    begin
      gate = pins[sel - 2'h1];
    end
    ctl_of = g[seq_pkg::G_LVL] & gate; // see [R15]
  endfunction

  // delay field to half-millisecond ticks
  function automatic logic [seq_pkg::CNT_W-1:0] ticks_of(input logic [3:0] code, input logic long_r);
    logic [seq_pkg::CNT_W-1:0] t;
    t = {1'b0, code}; // see [R03]
    if (long_r)
    begin
      t = {code, 1'b0}; // see [R04] [R16]
    end
    ticks_of = t;
  endfunction

  // register index decode
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i >= seq_pkg::IDX_SDB_DLY) && (i <= seq_pkg::IDX_STATUS);
  endfunction

  // ****************************************
  // bus and control decode
  // ****************************************
  always_comb
  begin
    req.sel = PSEL;
    req.en = PENABLE;
    req.wr = PWRITE;
    req.addr = PADDR;
    req.wdata = PWDATA[7:0];
    idx = req.addr[9:2];
    hit = is_mapped(idx) && (req.addr[1:0] == seq_pkg::ADDR_LOW) && (req.addr[31:10] == 22'h0);
    grp[seq_pkg::CH_SDB] = s_q.regs.rail[3:0];
    grp[seq_pkg::CH_UP] = s_q.regs.rail[7:4];
    grp[seq_pkg::CH_GA] = s_q.regs.ctrl1[3:0]; // see [R14]
    grp[seq_pkg::CH_GB] = s_q.regs.ctrl1[7:4]; // see [R14]
    grp[seq_pkg::CH_GC] = s_q.regs.ctrl_c[3:0];
    for (int c = 0; c < seq_pkg::NCH; c++)
    begin
      ctrl[c] = ctl_of(grp[c], s_q.pin_s2);
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic [7:0] rd;
    logic [3:0] code;
    logic long_r;
    rd = 8'h00;
    code = 4'h0;
    long_r = 1'b0;
    s_d = s_q;

    // ****************************************
    // pin synchronisers
    // ****************************************
    s_d.pin_s1 = {ENABLE_PIN_C, ENABLE_PIN_B, ENABLE_PIN_A};
    s_d.pin_s2 = s_q.pin_s1;

    // ****************************************
    // half-millisecond tick divider
    // ****************************************
    s_d.tick = 1'b0;
    if (s_q.presc >= 32'(TICK_CYCLES - 1))
    begin
      s_d.presc = 32'h0;
      s_d.tick = 1'b1; // see [R17]
    end
    else
    begin
      s_d.presc = s_q.presc + 32'h1;
    end

    // ****************************************
    // apb: one wait state, then answer
    // ****************************************
    s_d.pready = 1'b0;
    if (req.sel && req.en && !s_q.pready)
    begin
      s_d.pready = 1'b1;
      s_d.pslverr = !hit;
      case (idx)
        seq_pkg::IDX_SDB_DLY: rd = s_q.regs.dly[seq_pkg::CH_SDB];
        seq_pkg::IDX_UP_DLY: rd = s_q.regs.dly[seq_pkg::CH_UP];
        seq_pkg::IDX_GA_DLY: rd = s_q.regs.dly[seq_pkg::CH_GA];
        seq_pkg::IDX_GB_DLY: rd = s_q.regs.dly[seq_pkg::CH_GB];
        seq_pkg::IDX_GC_DLY: rd = s_q.regs.dly[seq_pkg::CH_GC];
        seq_pkg::IDX_CTRL1: rd = s_q.regs.ctrl1;
        seq_pkg::IDX_CTRL_C: rd = s_q.regs.ctrl_c;
        seq_pkg::IDX_CONFIG: rd = s_q.regs.config_r;
        seq_pkg::IDX_RAIL: rd = s_q.regs.rail;
        seq_pkg::IDX_STATUS: rd = {3'h0, s_q.out};
        default: rd = 8'h00;
      endcase
      s_d.prdata = 32'h0;
      if (!req.wr && hit)
      begin
        s_d.prdata = {24'h0, rd};
      end
    end

    // ****************************************
    // register writes at the completing edge
    // ****************************************
    if (req.sel && req.en && s_q.pready && req.wr && hit)
    begin
      case (idx)
        seq_pkg::IDX_SDB_DLY: s_d.regs.dly[seq_pkg::CH_SDB] = req.wdata; // see [R13]
        seq_pkg::IDX_UP_DLY: s_d.regs.dly[seq_pkg::CH_UP] = req.wdata; // see [R13]
        seq_pkg::IDX_GA_DLY: s_d.regs.dly[seq_pkg::CH_GA] = req.wdata; // see [R13]
        seq_pkg::IDX_GB_DLY: s_d.regs.dly[seq_pkg::CH_GB] = req.wdata; // see [R13]
        seq_pkg::IDX_GC_DLY: s_d.regs.dly[seq_pkg::CH_GC] = req.wdata; // see [R13]
        seq_pkg::IDX_CTRL1: s_d.regs.ctrl1 = req.wdata; // see [R14]
        seq_pkg::IDX_CTRL_C: s_d.regs.ctrl_c = {4'h0, req.wdata[3:0]};
        seq_pkg::IDX_CONFIG:
        begin
          s_d.regs.config_r = 8'h00;
          s_d.regs.config_r[seq_pkg::CFG_ON_LONG] = req.wdata[seq_pkg::CFG_ON_LONG];
          s_d.regs.config_r[seq_pkg::CFG_OFF_LONG] = req.wdata[seq_pkg::CFG_OFF_LONG];
        end
        seq_pkg::IDX_RAIL: s_d.regs.rail = req.wdata;
        default: s_d.regs = s_q.regs;
      endcase
    end

    // ****************************************
    // per-output delay timers
    // ****************************************
    for (int c = 0; c < seq_pkg::NCH; c++)
    begin
      s_d.ctrl_prev[c] = ctrl[c];
      if (ctrl[c] != s_q.ctrl_prev[c])
      begin
        // new edge reloads, dropping any pending delay
        if (ctrl[c])
        begin
          code = s_q.regs.dly[c][seq_pkg::ON_LSB +: 4]; // see [R01] [R05] [R07] [R09] [R11]
          long_r = s_q.regs.config_r[seq_pkg::CFG_ON_LONG]; // see [R04]
        end
        else
        begin
          code = s_q.regs.dly[c][seq_pkg::OFF_LSB +: 4]; // see [R02] [R06] [R08] [R10] [R12]
          long_r = s_q.regs.config_r[seq_pkg::CFG_OFF_LONG]; // see [R16]
        end
        s_d.cnt[c] = ticks_of(code, long_r); // see [R17] [R18]
        if (ticks_of(code, long_r) == '0)
        begin
          s_d.out[c] = ctrl[c];
        end
      end
      else if (s_q.cnt[c] != '0 && s_q.tick)
      begin
        s_d.cnt[c] = s_q.cnt[c] - 1'b1;
        if (s_q.cnt[c] == 5'h01)
        begin
          s_d.out[c] = s_q.ctrl_prev[c];
        end
      end
    end

    // ****************************************
    // general output pin drive, open-drain only pulls low
    // ****************************************
    for (int g = 0; g < 3; g++)
    begin
      if (grp[seq_pkg::CH_GA + g][seq_pkg::G_OD])
      begin
        s_d.go_o[g] = 1'b0;
        s_d.go_oe[g] = !s_d.out[seq_pkg::CH_GA + g];
      end
      else
      begin
        s_d.go_o[g] = s_d.out[seq_pkg::CH_GA + g];
        s_d.go_oe[g] = 1'b1;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      s_q <= '0;
      s_q.regs.dly <= {seq_pkg::NCH{seq_pkg::DLY_RST}}; // see [R13]
      s_q.regs.ctrl1 <= seq_pkg::CTRL1_RST; // see [R14]
      s_q.regs.ctrl_c <= seq_pkg::CTRL_C_RST;
      s_q.regs.config_r <= seq_pkg::CONFIG_RST;
      s_q.regs.rail <= seq_pkg::RAIL_RST;
      s_q.go_oe <= 3'h0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign STEP_DOWN_B_EN = s_q.out[seq_pkg::CH_SDB];
  assign STEP_UP_EN = s_q.out[seq_pkg::CH_UP];
  assign GENERAL_OUT_O = s_q.go_o;
  assign GENERAL_OUT_OE = s_q.go_oe;

endmodule // rail_output_delay_sequencer
`default_nettype wire

/* rod_chk.sv */
// port assertions of the rail output delay sequencer
`timescale 1ns/1ns
`default_nettype none
module rod_chk #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // general outputs
  input wire logic [2:0] GENERAL_OUT_O,
  input wire logic [2:0] GENERAL_OUT_OE
);
  // ****
  // checks
  // ****
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic hit;
  assign hit = PADDR[1:0] == 2'h0 && PADDR[31:2] >= 30'h0a && PADDR[31:2] <= 30'h13;
  a_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready long");
  a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE)) else $error("ready unasked");
  a_err_unmapped: assert property (PREADY && !hit |-> PSLVERR) else $error("no error");
  a_ok_mapped: assert property (PREADY && hit |-> !PSLVERR) else $error("false error");
  a_rdata_upper: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper data");
  a_err_zero: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0) else $error("error data");
  a_od_release: assert property ((GENERAL_OUT_O & ~GENERAL_OUT_OE) == 3'h0) else $error("pad drive");
endmodule // rod_chk
bind rail_output_delay_sequencer rod_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.REF_CLK(REF_CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .GENERAL_OUT_O(GENERAL_OUT_O), .GENERAL_OUT_OE(GENERAL_OUT_OE));
`default_nettype wire

/* rod_partner.sv */
// far side model: enable pin drivers and general output pads
`timescale 1ns/1ns
`default_nettype none
module rod_partner (
  // bench requests
  input wire logic [2:0] pin_req,
  // design pins
  input wire logic [2:0] o,
  input wire logic [2:0] oe,
  output logic [2:0] en_pins,
  output logic [2:0] pad
);
  // ****
  // pins and pads
  // ****
  assign en_pins = pin_req;
  // released pads are pulled up
  assign pad = (o & oe) | ~oe;
endmodule // rod_partner
`default_nettype wire

/* seq_pkg.sv */
// constants and carriers of the rail output delay sequencer
package seq_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_NS = 500000;
  localparam int STEP_CYCLES = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NCH = 5;
  localparam int CNT_W = 5;
  // channel numbers
  localparam int CH_SDB = 0;
  localparam int CH_UP = 1;
  localparam int CH_GA = 2;
  localparam int CH_GB = 3;
  localparam int CH_GC = 4;
  // register indexes, byte address is four times the index
  localparam logic [7:0] IDX_SDB_DLY = 8'h0a;
  localparam logic [7:0] IDX_UP_DLY = 8'h0b;
  localparam logic [7:0] IDX_GA_DLY = 8'h0c;
  localparam logic [7:0] IDX_GB_DLY = 8'h0d;
  localparam logic [7:0] IDX_GC_DLY = 8'h0e;
  localparam logic [7:0] IDX_CTRL1 = 8'h0f;
  localparam logic [7:0] IDX_CTRL_C = 8'h10;
  localparam logic [7:0] IDX_CONFIG = 8'h11;
  localparam logic [7:0] IDX_RAIL = 8'h12;
  localparam logic [7:0] IDX_STATUS = 8'h13;
  // fields
  localparam int ON_LSB = 0;
  localparam int OFF_LSB = 4;
  localparam int GRP_HI = 4;
  localparam int G_LVL = 0;
  localparam int G_SEL = 1;
  localparam int G_OD = 3;
  localparam int CFG_ON_LONG = 7;
  localparam int CFG_OFF_LONG = 6;
  // reset values
  localparam logic [7:0] DLY_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'haa;
  localparam logic [7:0] CTRL_C_RST = 8'h0a;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] RAIL_RST = 8'h00;
  localparam logic [1:0] ADDR_LOW = 2'h0;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [31:0] addr;
    logic [7:0] wdata;
  } apb_req_t;

  typedef struct packed {
    logic [NCH-1:0][7:0] dly;
    logic [7:0] ctrl1;
    logic [7:0] ctrl_c;
    logic [7:0] config_r;
    logic [7:0] rail;
  } regs_t;
endpackage

/* tb_rail_output_delay_sequencer.sv */
// self-checking bench of the rail output delay sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_rail_output_delay_sequencer;
  // ****
  // bench
  // ****
  localparam int T = 10;
  logic REF_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, sdb, up, err;
  logic [31:0] PADDR, PWDATA, PRDATA, rd;
  logic [2:0] req, pins, o, oe, pad;
  logic [4:0] outs;
  logic [3:0] on, off;
  logic [7:0] ca [5] = '{8'h48, 8'h48, 8'h3c, 8'h3c, 8'h40};
  logic [7:0] cb [5] = '{8'h01, 8'h10, 8'h01, 8'h10, 8'h01};
  int num_errors, n_compared, seed, cnt, mdl [32];
  assign outs = {pad, up, sdb};
  rail_output_delay_sequencer #(.TICK_CYCLES(T)) DUT (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .ENABLE_PIN_A(pins[0]), .ENABLE_PIN_B(pins[1]), .ENABLE_PIN_C(pins[2]),
    .STEP_DOWN_B_EN(sdb), .STEP_UP_EN(up), .GENERAL_OUT_O(o), .GENERAL_OUT_OE(oe));
  rod_partner u_far (.pin_req(req), .o(o), .oe(oe), .en_pins(pins), .pad(pad));
  initial
  begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  initial
  begin
    repeat (40000) @(posedge REF_CLK);
    num_errors++;
    close_out;
  end
  task close_out;
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1)
      @(posedge REF_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (w && !err)
      mdl[a[6:2]] = d;
  endtask
  task meas(input int ch, input logic v, input int n);
    cnt = 0;
    while (outs[ch] !== v && cnt < 400)
    begin
      @(posedge REF_CLK);
      cnt++;
    end
    chk(cnt >= (n - 1) * T && cnt <= n * T + 8, 1);
  endtask
  initial
  begin
    seed = 94;
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 32'h0;
    PWDATA = 32'h0;
    req = 3'h0;
    for (int i = 10; i < 17; i++)
      mdl[i] = (i == 15) ? 8'haa : (i == 16) ? 8'h0a : 8'h00;
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    for (int i = 10; i < 17; i++)
    begin
      apb(0, i * 4, 8'h00);
      chk(rd, mdl[i]);
    end
    chk({oe, pad}, 6'h38);
    apb(1, 32'h80, 8'h5a);
    chk(err, 1'b1);
    apb(0, 32'h29, 8'h00);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    for (int i = 10; i < 15; i++)
    begin
      apb(1, i * 4, 8'($random(seed)));
      apb(0, i * 4, 8'h00);
      chk(rd, mdl[i]);
    end
    apb(1, 32'h3c, 8'h00);
    apb(1, 32'h40, 8'h00);
    for (int r = 0; r < 4; r++)
      for (int ch = 0; ch < 5; ch++)
      begin
        on = (r == 3) ? 4'hf : 4'($random(seed));
        off = (r == 0) ? 4'h0 : 4'($random(seed));
        apb(1, 32'h44, 8'(r << 6));
        apb(1, (10 + ch) * 4, {off, on});
        apb(1, ca[ch], cb[ch]);
        meas(ch, 1'b1, on * (r[1] ? 2 : 1));
        apb(1, ca[ch], 8'h00);
        meas(ch, 1'b0, off * (r[0] ? 2 : 1));
      end
    apb(1, 32'h28, 8'h0f);
    apb(1, 32'h48, 8'h01);
    repeat (150) @(posedge REF_CLK);
    apb(1, 32'h48, 8'h00);
    repeat (200) @(posedge REF_CLK);
    chk(sdb, 1'b0);
    apb(1, 32'h48, 8'h01);
    meas(0, 1'b1, 30);
    apb(1, 32'h30, 8'h00);
    for (int s = 1; s < 4; s++)
    begin
      req <= ~(3'h1 << (s - 1));
      apb(1, 32'h3c, 8'(s * 2 + 1));
      repeat (20) @(posedge REF_CLK);
      chk(pad[0], 1'b0);
      req <= 3'h7;
      meas(2, 1'b1, 0);
    end
    apb(1, 32'h3c, 8'h09);
    repeat (4) @(posedge REF_CLK);
    chk({oe[0], o[0], pad[0]}, 3'h1);
    apb(0, 32'h4c, 8'h00);
    chk(rd, 32'h05);
    close_out;
  end
endmodule // tb_rail_output_delay_sequencer
`default_nettype wire
